// ---- design/mfs_pkg.sv ----
package mfs_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0]  REG_CTRL    = 5'h00;
	localparam logic [4:0]  REG_COUNT   = 5'h04;
	localparam logic [4:0]  REG_STATUS  = 5'h08;
	localparam logic [4:0]  REG_IRQSTAT = 5'h0c;
	localparam logic [4:0]  REG_IRQMASK = 5'h10;

	localparam int          CTRL_GO_BIT = 8;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [2:0]  IRQ_RST     = 3'h0;

	// ----------------------------------------
	// Interrupt bit positions
	// ----------------------------------------
	localparam int IRQ_DONE = 0;
	localparam int IRQ_UCHK = 1;
	localparam int IRQ_REJ  = 2;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_SCAN_EQ = 8'h2d;
	localparam logic [7:0] CMD_SCAN_HI = 8'h4d;
	localparam logic [7:0] CMD_SCAN_HE = 8'h6d;
	localparam logic [7:0] CMD_MT_MASK = 8'h80;

	// ----------------------------------------
	// Ending status bits
	// ----------------------------------------
	localparam logic [7:0] ST_SM = 8'h40;
	localparam logic [7:0] ST_CE = 8'h08;
	localparam logic [7:0] ST_DE = 8'h04;
	localparam logic [7:0] ST_UC = 8'h02;

	localparam logic [7:0] MASK_SKIP   = 8'hff;
	localparam logic [1:0] INDEX_LIMIT = 2'd2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {CondEq, CondHi, CondHe} mfs_cond_t;
	typedef enum logic [1:0] {RelEq, RelHi, RelLo} mfs_rel_t;
	typedef enum logic [2:0] {StIdle, StWaitRec, StCompare, StJudge} mfs_state_t;

endpackage

// ---- design/mfs_cmp_if.sv ----
`timescale 1ns/1ns
interface mfs_cmp_if;
	import mfs_pkg::*;
	logic       clear;
	logic       step;
	logic [7:0] fieldByte;
	logic [7:0] maskByte;
	mfs_rel_t   rel;
	modport ctl  (output clear, output step, output fieldByte, output maskByte, input rel);
	modport unit (input clear, input step, input fieldByte, input maskByte, output rel);
endinterface

// ---- design/mfs_compare.sv ----
`timescale 1ns/1ns
module mfs_compare (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// Compare channel
	mfs_cmp_if.unit   cmp
);
	import mfs_pkg::*;

	typedef struct packed {
		mfs_rel_t rel;
	} mfs_cmp_state_t;

	mfs_cmp_state_t st_r;
	mfs_cmp_state_t st_nxt;

	// ----------------------------------------
	// Byte relation update
	// ----------------------------------------
	function automatic mfs_rel_t nextRel(mfs_rel_t cur, logic [7:0] f, logic [7:0] m);
		mfs_rel_t r;
		r = cur;
		if (m != MASK_SKIP && cur == RelEq) begin
			if (f > m) begin
				r = RelHi;
			end else if (f < m) begin
				r = RelLo;
			end
		end
		return r;
	endfunction

	always_comb begin
		st_nxt = st_r;
		if (cmp.clear) begin
			st_nxt.rel = RelEq;
		end else if (cmp.step) begin
			st_nxt.rel = nextRel(st_r.rel, cmp.fieldByte, cmp.maskByte);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{rel: RelEq};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmp.rel = st_r.rel;

endmodule

// ---- design/mfs_scan_search.sv ----
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
//
// Contract
// - Decode equal, high, high-or-equal scan commands
// - Accept each command with or without multitrack
// - Skip all-ones mask positions, compare others
// - Satisfied adds status modifier to CE DE
// - Multitrack searches tracks until cylinder end
// - Single track: two index marks, record not found
// - Zero key length compares data only
// - Long count ends when field length exhausted
// - Parity, overrun, data check give unit check
module mfs_scan_search (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt
	output logic             irq,
	// Channel mask stream and ending status
	input  wire logic [7:0]  maskByte,
	input  wire logic        maskValid,
	output logic             maskReady,
	output logic      [7:0]  endStatus,
	output logic             endStatusValid,
	// Disk record stream
	input  wire logic        recStart,
	input  wire logic [7:0]  keyFieldLength,
	input  wire logic [15:0] dataFieldLength,
	input  wire logic [7:0]  fieldByte,
	input  wire logic        fieldValid,
	input  wire logic        indexMark,
	input  wire logic        endOfCylinder,
	output logic             trackAdvance,
	// Error reports
	input  wire logic        busOutParityErr,
	input  wire logic        overrunErr,
	input  wire logic        dataCheckErr
);
	import mfs_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mfs_state_t  state;
		mfs_cond_t   cond;
		logic        multitrack;
		logic [7:0]  command;
		logic [15:0] count;
		logic [16:0] remain;
		logic [1:0]  indexSeen;
		logic        errSeen;
		logic        noRecord;
		logic        cylEnd;
		logic [7:0]  lastStatus;
		logic [7:0]  endStatus;
		logic        endValid;
		logic        trackAdv;
		logic [2:0]  irqStat;
		logic [2:0]  irqMask;
		logic        ack;
		logic [31:0] rdata;
	} mfs_main_state_t;

	mfs_main_state_t st_r;
	mfs_main_state_t st_nxt;

	mfs_cmp_if cmpBus ();

	mfs_compare u_compare (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.cmp      (cmpBus)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic isScan(logic [7:0] cmd);
		logic [7:0] base;
		base = cmd & ~CMD_MT_MASK;
		return (base == CMD_SCAN_EQ) || (base == CMD_SCAN_HI) || (base == CMD_SCAN_HE);
	endfunction

	function automatic logic condMet(mfs_cond_t c, mfs_rel_t r);
		logic ok;
		case (c)
			CondEq: begin
				ok = (r == RelEq);
			end
			CondHi: begin
				ok = (r == RelHi);
			end
			CondHe: begin
				ok = (r != RelLo);
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	function automatic logic [16:0] cmpLength(logic [15:0] cnt, logic [16:0] len);
		logic [16:0] n;
		if ({1'b0, cnt} < len) begin
			n = {1'b0, cnt};
		end else begin
			n = len;
		end
		return n;
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        busGo;
	logic        wrStrobe;
	logic        rdFirst;
	logic [16:0] recLen;
	logic [7:0]  baseCmd;
	logic [2:0]  irqEvents;
	logic [7:0]  finStatus;
	logic        finish;
	logic        finUc;
	logic        takeByte;

	assign wrStrobe = avs_write && st_r.ack;
	assign rdFirst  = avs_read && !st_r.ack;
	assign busGo    = wrStrobe && (avs_address == REG_CTRL) && avs_writedata[CTRL_GO_BIT];
	assign recLen   = {9'h000, keyFieldLength} + {1'b0, dataFieldLength};
	assign baseCmd  = avs_writedata[7:0] & ~CMD_MT_MASK;

	assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
	assign avs_readdata    = st_r.rdata;
	assign irq             = |(st_r.irqStat & st_r.irqMask);
	assign endStatus       = st_r.endStatus;
	assign endStatusValid  = st_r.endValid;
	assign trackAdvance    = st_r.trackAdv;

	// ----------------------------------------
	// Field and mask bytes
	// ----------------------------------------
	// A field byte counts only while compare length remains
	assign takeByte           = (st_r.state == StCompare) && fieldValid && (st_r.remain != 17'h00000);
	assign maskReady          = takeByte;
	assign cmpBus.clear       = (st_r.state == StWaitRec) && recStart;
	assign cmpBus.step        = takeByte && maskValid;
	assign cmpBus.fieldByte   = fieldByte;
	assign cmpBus.maskByte    = maskByte;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt    = st_r;
		irqEvents = 3'h0;
		finish    = 1'b0;
		finUc     = 1'b0;
		finStatus = ST_CE | ST_DE;

		st_nxt.endValid = 1'b0;
		st_nxt.trackAdv = 1'b0;
		st_nxt.ack      = (avs_read || avs_write) && !st_r.ack;

		// Register reads
		if (rdFirst) begin
			case (avs_address)
				REG_CTRL: begin
					st_nxt.rdata = {24'h000000, st_r.command};
				end
				REG_COUNT: begin
					st_nxt.rdata = {16'h0000, st_r.count};
				end
				REG_STATUS: begin
					st_nxt.rdata = {21'h000000, st_r.cylEnd, st_r.noRecord,
						st_r.state != StIdle, st_r.lastStatus};
				end
				REG_IRQSTAT: begin
					st_nxt.rdata = {29'h00000000, st_r.irqStat};
				end
				REG_IRQMASK: begin
					st_nxt.rdata = {29'h00000000, st_r.irqMask};
				end
				default: begin
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end

		// Register writes
		if (wrStrobe) begin
			case (avs_address)
				REG_COUNT: begin
					st_nxt.count = avs_writedata[15:0];
				end
				REG_IRQSTAT: begin
					st_nxt.irqStat = st_r.irqStat & ~avs_writedata[2:0];
				end
				REG_IRQMASK: begin
					st_nxt.irqMask = avs_writedata[2:0];
				end
				default: begin
				end
			endcase
		end

		// Errors gathered while a search runs
		if (st_r.state != StIdle && (busOutParityErr || overrunErr || dataCheckErr)) begin
			st_nxt.errSeen = 1'b1;
		end

		case (st_r.state)
			StIdle: begin
				if (busGo) begin
					st_nxt.command = avs_writedata[7:0];
					if (isScan(avs_writedata[7:0])) begin
						st_nxt.multitrack = avs_writedata[7];
						case (baseCmd)
							CMD_SCAN_EQ: begin
								st_nxt.cond = CondEq;
							end
							CMD_SCAN_HI: begin
								st_nxt.cond = CondHi;
							end
							default: begin
								st_nxt.cond = CondHe;
							end
						endcase
						st_nxt.state     = StWaitRec;
						st_nxt.indexSeen = 2'd0;
						st_nxt.errSeen   = 1'b0;
						st_nxt.noRecord  = 1'b0;
						st_nxt.cylEnd    = 1'b0;
					end else begin
						irqEvents[IRQ_REJ] = 1'b1;
						st_nxt.endStatus   = ST_CE | ST_DE | ST_UC;
						st_nxt.lastStatus  = ST_CE | ST_DE | ST_UC;
						st_nxt.endValid    = 1'b1;
					end
				end
			end
			StWaitRec: begin
				if (indexMark) begin
					if (st_r.multitrack) begin
						if (endOfCylinder) begin
							st_nxt.cylEnd = 1'b1;
							finish        = 1'b1;
						end else begin
							st_nxt.trackAdv = 1'b1;
						end
					end else if (st_r.indexSeen + 2'd1 == INDEX_LIMIT) begin
						st_nxt.noRecord = 1'b1;
						finUc           = 1'b1;
						finish          = 1'b1;
					end else begin
						st_nxt.indexSeen = st_r.indexSeen + 2'd1;
					end
				end else if (recStart) begin
					// Compare length is the shorter of count and key plus data
					st_nxt.remain = cmpLength(st_r.count, recLen);
					st_nxt.state = StCompare;
				end
			end
			StCompare: begin
				if (takeByte && !maskValid) begin
					st_nxt.errSeen = 1'b1;
				end
				if (st_r.remain == 17'h00000) begin
					st_nxt.state = StJudge;
				end else if (fieldValid) begin
					st_nxt.remain = st_r.remain - 17'h00001;
				end
			end
			StJudge: begin
				if (condMet(st_r.cond, cmpBus.rel)) begin
					finStatus = ST_CE | ST_DE | ST_SM;
					finish    = 1'b1;
				end else begin
					st_nxt.state = StWaitRec;
				end
			end
			default: begin
				st_nxt.state = StIdle;
			end
		endcase

		// Ending status
		if (finish) begin
			if (finUc || st_nxt.errSeen) begin
				finStatus          = finStatus | ST_UC;
				irqEvents[IRQ_UCHK] = 1'b1;
			end
			irqEvents[IRQ_DONE] = 1'b1;
			st_nxt.endStatus    = finStatus;
			st_nxt.lastStatus   = finStatus;
			st_nxt.endValid     = 1'b1;
			st_nxt.state        = StIdle;
		end

		// New events win over a clear in the same cycle
		st_nxt.irqStat = st_nxt.irqStat | irqEvents;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{
				state:      StIdle,
				cond:       CondEq,
				multitrack: 1'b0,
				command:    8'h00,
				count:      COUNT_RST,
				remain:     17'h00000,
				indexSeen:  2'd0,
				errSeen:    1'b0,
				noRecord:   1'b0,
				cylEnd:     1'b0,
				lastStatus: 8'h00,
				endStatus:  8'h00,
				endValid:   1'b0,
				trackAdv:   1'b0,
				irqStat:    IRQ_RST,
				irqMask:    IRQ_RST,
				ack:        1'b0,
				rdata:      32'h00000000
			};
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// ---- tb/mfs_scan_search_sva.sv ----
`timescale 1ns/1ns
module mfs_scan_search_sva
	import mfs_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_b,
	// Watched ports
	input wire logic [4:0]  avs_address,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_writedata,
	input wire logic        maskReady,
	input wire logic        fieldValid,
	input wire logic [7:0]  endStatus,
	input wire logic        endStatusValid,
	input wire logic        trackAdvance,
	input wire logic        busOutParityErr,
	input wire logic        overrunErr,
	input wire logic        dataCheckErr
);
	logic       errSeen_r;
	logic       busy_r;
	logic       goSeen;
	logic [7:0] cmd_r;
	// Start of a search as the design takes it
	assign goSeen = avs_write && !avs_waitrequest && avs_address == REG_CTRL && avs_writedata[CTRL_GO_BIT] &&
		(!busy_r || endStatusValid);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Last started command and errors since last ending
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			errSeen_r <= 1'b0;
			busy_r    <= 1'b0;
			cmd_r     <= 8'h00;
		end else begin
			if (goSeen) begin
				cmd_r  <= avs_writedata[7:0];
				busy_r <= 1'b1;
			end else if (endStatusValid) begin
				busy_r <= 1'b0;
			end
			errSeen_r <= (errSeen_r && !endStatusValid) || busOutParityErr || overrunErr || dataCheckErr;
		end
	end
	// ----------
	// Assertions
	// ----------
	status_form_a: assert property (endStatusValid |-> (endStatus & ~(ST_SM | ST_UC)) == (ST_CE | ST_DE))
		else $error("ending status malformed");
	status_pulse_a: assert property (endStatusValid |=> !endStatusValid)
		else $error("ending status valid too long");
	status_hold_a: assert property (!endStatusValid |-> $stable(endStatus))
		else $error("ending status changed without valid");
	err_check_a: assert property (endStatusValid && errSeen_r |-> (endStatus & ST_UC) == ST_UC)
		else $error("error without unit check");
	mt_advance_a: assert property (trackAdvance |-> cmd_r[7])
		else $error("track advance in single track");
	adv_pulse_a: assert property (trackAdvance |=> !trackAdvance)
		else $error("track advance too long");
	mask_take_a: assert property (maskReady |-> fieldValid && busy_r)
		else $error("mask taken outside a search");
	judge_gap_a: assert property (endStatusValid |-> !$past(maskReady))
		else $error("ending without decide cycle");
	sat_c: cover property (endStatusValid && endStatus[6]);
	adv_c: cover property (trackAdvance);
	uc_c: cover property (endStatusValid && endStatus[1]);
endmodule
bind mfs_scan_search mfs_scan_search_sva chk_u (.core_clk, .rst_b, .avs_address, .avs_write, .avs_waitrequest,
	.avs_writedata, .maskReady, .fieldValid, .endStatus, .endStatusValid, .trackAdvance, .busOutParityErr,
	.overrunErr, .dataCheckErr);

// ---- tb/mfs_channel_model.sv ----
`timescale 1ns/1ns
module mfs_channel_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Mask stream
	input  wire logic       recStart,
	input  wire logic       maskReady,
	output logic      [7:0] maskByte,
	output logic            maskValid
);
	logic [7:0] mem [0:7];
	logic [2:0] len = 3'h0;
	logic [3:0] idx_r;
	// One mask byte per field byte, all-ones bytes passed as given
	assign maskValid = rst_b && idx_r < {1'b0, len};
	assign maskByte  = maskValid ? mem[idx_r[2:0]] : ~mem[idx_r[2:0] - 3'd1];
	// Fresh mask stream for each record attempt
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			idx_r <= 4'h0;
		else if (recStart)
			idx_r <= 4'h0;
		else if (maskReady && maskValid)
			idx_r <= idx_r + 4'h1;
	end
endmodule

// ---- tb/mfs_scan_search_bench.sv ----
`timescale 1ns/1ns
module mfs_scan_search_bench;
	import mfs_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, irq, maskValid, maskReady, endStatusValid, trackAdvance;
	logic [7:0]  maskByte, endStatus, lastSt, cmd, es;
	logic        recStart = 1'b0, fieldValid = 1'b0, indexMark = 1'b0, endOfCylinder = 1'b0;
	logic        dataCheckErr = 1'b0, busOutParityErr = 1'b0, overrunErr = 1'b0;
	logic [7:0]  keyFieldLength = 8'h00, fieldByte = 8'h00;
	logic [15:0] dataFieldLength = 16'h0000;
	int          mismatches = 0, cmp_count = 0, ends = 0, advs = 0, a;
	always #50 core_clk = ~core_clk;
	mfs_scan_search dut_u (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .irq, .maskByte, .maskValid, .maskReady, .endStatus, .endStatusValid, .recStart,
		.keyFieldLength, .dataFieldLength, .fieldByte, .fieldValid, .indexMark, .endOfCylinder, .trackAdvance,
		.busOutParityErr, .overrunErr, .dataCheckErr);
	mfs_channel_model chan_u (.core_clk, .rst_b, .recStart, .maskReady, .maskByte, .maskValid);
	always @(posedge core_clk) begin
		if (endStatusValid) begin
			lastSt <= endStatus;
			ends <= ends + 1;
		end
		if (trackAdvance)
			advs <= advs + 1;
	end
	// -----
	// Tasks
	// -----
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
		logic w;
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Values read mid-cycle are those standing at the next rising edge
		do begin
			@(negedge core_clk);
			w = avs_waitrequest;
			rd = avs_readdata;
			@(posedge core_clk);
		end while (w !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic chk_irq(input logic want);
		@(negedge core_clk);
		check(irq, want);
		@(posedge core_clk);
	endtask
	task automatic search(input logic [7:0] c, input logic [7:0] kl, input logic [2:0] err, input logic [23:0] f,
		input logic [23:0] m, input logic [7:0] want);
		int n;
		n = ends;
		for (int i = 0; i < 3; i++)
			chan_u.mem[i] = m[23-8*i -: 8];
		chan_u.len = 3'd3;
		bus(1'b1, REG_CTRL, {23'h0, 1'b1, c});
		recStart <= 1'b1;
		keyFieldLength <= kl;
		dataFieldLength <= 16'd3 - {8'h00, kl};
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			recStart <= 1'b0;
			fieldValid <= 1'b1;
			dataCheckErr <= err[0] && i == 0;
			busOutParityErr <= err[1] && i == 1;
			overrunErr <= err[2] && i == 2;
			fieldByte <= f[23-8*i -: 8];
		end
		@(posedge core_clk);
		fieldValid <= 1'b0;
		dataCheckErr <= 1'b0;
		busOutParityErr <= 1'b0;
		overrunErr <= 1'b0;
		for (int k = 0; k < 2 && !want[6]; k++) begin
			repeat (4) @(posedge core_clk);
			indexMark <= 1'b1;
			endOfCylinder <= c[7] && k == 1;
			@(posedge core_clk);
			indexMark <= 1'b0;
			endOfCylinder <= 1'b0;
		end
		for (int j = 0; j < 50 && ends == n; j++)
			@(posedge core_clk);
		@(negedge core_clk);
		check(ends, n + 1);
		check(lastSt, want);
		@(posedge core_clk);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#3000000;
		mismatches++;
		close_out;
	end
	// -----
	// Tests
	// -----
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		bus(1'b1, REG_COUNT, 32'h100);
		bus(1'b1, REG_IRQMASK, 32'h7);
		for (int c = 0; c < 6; c++) begin
			cmd = (c % 3 == 0) ? CMD_SCAN_EQ : (c % 3 == 1) ? CMD_SCAN_HI : CMD_SCAN_HE;
			cmd = (c > 2) ? cmd | CMD_MT_MASK : cmd;
			es = (c % 3 != 1) ? ST_CE | ST_DE | ST_SM : (c > 2) ? ST_CE | ST_DE : ST_CE | ST_DE | ST_UC;
			a = advs;
			search(cmd, 8'd1, 3'h0, 24'h102030, 24'h10ff30, es);
			check(advs - a, (c == 4) ? 1 : 0);
			bus(1'b0, REG_STATUS, 32'h0);
			check(rd[10:0], {c == 4, c == 1, 1'b0, es});
			$display("command %h done", cmd);
		end
		search(CMD_SCAN_HI, 8'd0, 3'h0, 24'h203100, 24'h1fffff, ST_CE | ST_DE | ST_SM);
		$display("data only done");
		bus(1'b1, REG_IRQSTAT, 32'h7);
		chk_irq(1'b0);
		// Data check, outbound parity and overrun, one search each
		for (int e = 0; e < 3; e++)
			search(CMD_SCAN_EQ, 8'd1, 3'h1 << e, 24'h102030, 24'h10ff30, ST_CE | ST_DE | ST_SM | ST_UC);
		bus(1'b0, REG_IRQSTAT, 32'h0);
		check(rd, 32'h3);
		chk_irq(1'b1);
		bus(1'b1, REG_IRQMASK, 32'h0);
		chk_irq(1'b0);
		bus(1'b1, REG_IRQMASK, 32'h7);
		chk_irq(1'b1);
		bus(1'b1, REG_IRQSTAT, 32'h3);
		chk_irq(1'b0);
		// A command outside the scan set is refused at once
		bus(1'b1, REG_CTRL, 32'h12e);
		chk_irq(1'b1);
		check(lastSt, ST_CE | ST_DE | ST_UC);
		bus(1'b0, REG_IRQSTAT, 32'h0);
		check(rd, 32'h4);
		bus(1'b0, 5'h14, 32'h0);
		check(rd, 32'h0);
		$display("error and interrupt done");
		close_out;
	end
endmodule
